// ==== testbench/ddrtg_host_properties.sv ====
`timescale 1ns/1ns
module ddrtg_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Memory side
  input wire ddrtg_pkg::ddrtg_pins_t pins,
  input wire logic [7:0] dq_oe_n,
  input wire logic [7:0] dqs_out,
  input wire logic [7:0] dqs_oe_n
);
  logic [2:0] c, bk, bact_reg;
  logic on, act, rd, wr, pre, rf;
  logic [15:0] tref_reg, tact_reg, twr_reg;
  assign c = {pins.ras_n, pins.cas_n, pins.we_n};
  assign on = pins.cs_n != 2'h3 && pins.cke;
  assign bk = {pins.cs_n[0], pins.ba};
  assign act = on && c == ddrtg_pkg::CMD_ACT;
  assign rd = on && c == ddrtg_pkg::CMD_READ;
  assign wr = on && c == ddrtg_pkg::CMD_WRITE;
  assign pre = on && c == ddrtg_pkg::CMD_PRE && ^pins.cs_n;
  assign rf = on && c == ddrtg_pkg::CMD_REF;
  // Counters saturate so that a long idle never wraps into a false short gap.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tref_reg <= 16'hffff;
      tact_reg <= 16'hffff;
      twr_reg <= 16'hffff;
      bact_reg <= 3'h0;
    end else begin
      tref_reg <= rf ? 16'h0001 : tref_reg + {15'h0000, ~&tref_reg};
      tact_reg <= act ? 16'h0001 : tact_reg + {15'h0000, ~&tact_reg};
      twr_reg <= wr ? 16'h0001 : twr_reg + {15'h0000, ~&twr_reg};
      bact_reg <= act ? bk : bact_reg;
    end
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_rfc; act || rf |-> tref_reg >= ddrtg_pkg::RFC_CYC; endproperty
  a_rfc: assert property (p_rfc) else $error("command inside refresh time");
  property p_rcd; (rd || wr) && bk == bact_reg |-> tact_reg >= ddrtg_pkg::RCD_CYC; endproperty
  a_rcd: assert property (p_rcd) else $error("access too soon after activate");
  property p_rrd; act |-> tact_reg >= ddrtg_pkg::RRD_CYC; endproperty
  a_rrd: assert property (p_rrd) else $error("activates too close");
  property p_wtr; rd |-> twr_reg >= ddrtg_pkg::WTR_CYC + ddrtg_pkg::BURST_LEN + 1; endproperty
  a_wtr: assert property (p_wtr) else $error("read too soon after write");
  property p_cke; rf || tref_reg < ddrtg_pkg::RFC_CYC |-> pins.cke; endproperty
  a_cke: assert property (p_cke) else $error("clock enable low in refresh");
  property p_ras; (pre || (rd || wr) && pins.addr[ddrtg_pkg::AP_BIT]) && bk == bact_reg
    |-> tact_reg >= ddrtg_pkg::RAS_MIN_CYC; endproperty
  a_ras: assert property (p_ras) else $error("bank closed too early");
  property p_lane; wr |=> (dq_oe_n == 8'h00) [*4] ##1 dq_oe_n == 8'hff; endproperty
  a_lane: assert property (p_lane) else $error("write lanes not driven");
  property p_pre; wr |-> dqs_oe_n == 8'h00; endproperty
  a_pre: assert property (p_pre) else $error("strobe not driven at write");
  property p_dqs; wr |=> dqs_out == 8'hff ##1 dqs_out == 8'h00 ##1 dqs_out == 8'hff
    ##1 dqs_out == 8'h00; endproperty
  a_dqs: assert property (p_dqs) else $error("write strobe wrong");
endmodule : ddrtg_chk

// ==== testbench/ddrtg_mem.sv ====
`timescale 1ns/1ns
module ddrtg_mem (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Command and write data
  input wire ddrtg_pkg::ddrtg_pins_t pins,
  input wire logic [63:0] dq_out,
  input wire logic [7:0] dq_oe_n,
  // Read data and strobes
  output logic [63:0] dq_in,
  output logic [7:0] dqs_in
);
  logic [255:0] mem [8];
  logic [2:0] c, bk_reg;
  logic [1:0] wi_reg, ri_reg;
  logic [3:0] rc_reg;
  logic on;
  assign c = {pins.ras_n, pins.cas_n, pins.we_n};
  assign on = pins.cs_n != 2'h3 && pins.cke;
  // Beats are taken once all lanes drive, with no demand on preamble setup.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rc_reg <= 4'h0;
      dqs_in <= 8'h00;
      dq_in <= 64'h0000000000000000;
      wi_reg <= 2'h0;
      ri_reg <= 2'h0;
      bk_reg <= 3'h0;
    end else begin
      if (on && (c == ddrtg_pkg::CMD_READ || c == ddrtg_pkg::CMD_WRITE)) begin
        bk_reg <= {pins.cs_n[0], pins.ba};
        wi_reg <= 2'h0;
        ri_reg <= 2'h0;
      end
      if (on && c == ddrtg_pkg::CMD_READ)
        rc_reg <= 4'(ddrtg_pkg::CAS_LAT + ddrtg_pkg::BURST_LEN);
      else if (rc_reg != 4'h0)
        rc_reg <= rc_reg - 4'h1;
      // A released data bus keeps changing, so a stale beat cannot pass.
      if (rc_reg inside {[4'h1:4'h4]}) begin
        dqs_in <= ~dqs_in;
        dq_in <= mem[bk_reg][ri_reg*64 +: 64];
        ri_reg <= ri_reg + 2'h1;
      end else begin
        dq_in <= ~dq_in;
      end
      if (dq_oe_n == 8'h00) begin
        mem[bk_reg][wi_reg*64 +: 64] <= dq_out;
        wi_reg <= wi_reg + 2'h1;
      end
    end
  end
endmodule : ddrtg_mem

// ==== testbench/test_ddrtg_host.sv ====
`timescale 1ns/1ns
module test_ddrtg_host;
  typedef struct packed {
    ddrtg_pkg::ddrtg_req_t q;
    logic [255:0] d;
  } ddrtg_row_t;
  localparam logic [255:0] DA = {64'h3, 64'h2, 64'h1, 64'h0} ^ {4{64'h8877665544332211}};
  logic clock = 1'b0;
  logic rstn = 1'b0;
  ddrtg_pkg::ddrtg_req_t req = '0;
  logic req_valid = 1'b0;
  logic [255:0] wr_data = '0;
  logic req_done, rd_valid, in_sref;
  logic [255:0] rd_data;
  ddrtg_pkg::ddrtg_pins_t pins;
  logic [63:0] dq_out, dq_in;
  logic [7:0] dq_oe_n, dqs_out, dqs_oe_n, dqs_in;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int nref = 0;
  int t0, t1, t2;
  ddrtg_row_t rows [9];
  ddrtg_host #(.T_RAS_MAX_NS(2000), .T_REFC_NS(2000)) i_ddrtg_host (.clock(clock), .rstn(rstn),
    .req(req), .req_valid(req_valid), .req_done(req_done), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .in_sref(in_sref), .pins(pins), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .dq_in(dq_in), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .dqs_in(dqs_in));
  ddrtg_mem i_ddrtg_mem (.clock(clock), .rstn(rstn), .pins(pins), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .dq_in(dq_in), .dqs_in(dqs_in));
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (pins.cs_n == 2'h0 && pins.cke && {pins.ras_n, pins.cas_n, pins.we_n} == 3'h1)
      nref <= nref + 1;
  end
  function automatic ddrtg_pkg::ddrtg_req_t mk(input ddrtg_pkg::ddrtg_op_t op, input logic r,
                                              input logic [1:0] b, input logic ap);
    mk = '{op: op, rank: r, ba: b, addr: 13'h0040, ap: ap};
  endfunction : mk
  task automatic check(input string nm, input logic [255:0] s, input logic [255:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic issue(input ddrtg_pkg::ddrtg_req_t q, input logic [255:0] d, output int t);
    int k;
    @(negedge clock);
    req = q;
    wr_data = d;
    req_valid = 1'b1;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (req_done !== 1'b1 && k < 3000);
    req_valid = 1'b0;
    t = cyc;
    check("req_done", req_done, 1'b1);
  endtask : issue
  task automatic wait_rd(input logic [255:0] e);
    int k;
    k = 0;
    while (rd_valid !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    check("rd_valid", rd_valid, 1'b1);
    check("rd_data", rd_data, e);
  endtask : wait_rd
  task automatic complete_run;
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // The run needs about 1650 cycles; a limit of 25000 cycles, some fifteen times that, marks a hang.
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  initial begin
    rows = '{'{mk(ddrtg_pkg::OP_ACT, 1'b0, 2'h0, 1'b0), DA},
             '{mk(ddrtg_pkg::OP_ACT, 1'b1, 2'h2, 1'b0), DA},
             '{mk(ddrtg_pkg::OP_WRITE, 1'b0, 2'h0, 1'b0), DA},
             '{mk(ddrtg_pkg::OP_WRITE, 1'b1, 2'h2, 1'b0), ~DA},
             '{mk(ddrtg_pkg::OP_READ, 1'b0, 2'h0, 1'b0), DA},
             '{mk(ddrtg_pkg::OP_READ, 1'b1, 2'h2, 1'b0), ~DA},
             '{mk(ddrtg_pkg::OP_PRE, 1'b0, 2'h0, 1'b0), DA},
             '{mk(ddrtg_pkg::OP_PRE, 1'b1, 2'h2, 1'b0), DA},
             '{mk(ddrtg_pkg::OP_MRS, 1'b0, 2'h0, 1'b0), DA}};
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].q, rows[i].d, t0);
      if (rows[i].q.op == ddrtg_pkg::OP_READ)
        wait_rd(rows[i].d);
    end
    rstn = 1'b0;
    @(negedge clock);
    check("pins", pins, ddrtg_pkg::PINS_IDLE);
    check("dq_oe_n", dq_oe_n, 8'hff);
    check("dqs_oe_n", dqs_oe_n, 8'hff);
    rstn = 1'b1;
    issue(mk(ddrtg_pkg::OP_ACT, 1'b1, 2'h2, 1'b0), DA, t0);
    issue(mk(ddrtg_pkg::OP_ACT, 1'b0, 2'h3, 1'b0), DA, t1);
    check("trrd", t1 - t0 >= ddrtg_pkg::RRD_CYC, 1'b1);
    issue(mk(ddrtg_pkg::OP_READ, 1'b1, 2'h2, 1'b1), DA, t2);
    check("tras", t2 - t0 >= ddrtg_pkg::RAS_MIN_CYC, 1'b1);
    wait_rd(~DA);
    issue(mk(ddrtg_pkg::OP_PRE, 1'b0, 2'h3, 1'b0), DA, t0);
    issue(mk(ddrtg_pkg::OP_SREF_IN, 1'b0, 2'h0, 1'b0), DA, t0);
    @(negedge clock);
    check("in_sref", in_sref, 1'b1);
    repeat (100) @(negedge clock);
    issue(mk(ddrtg_pkg::OP_SREF_OUT, 1'b0, 2'h0, 1'b0), DA, t0);
    issue(mk(ddrtg_pkg::OP_ACT, 1'b0, 2'h0, 1'b0), DA, t1);
    check("txsnr", t1 - t0 >= ddrtg_pkg::XSNR_CYC, 1'b1);
    issue(mk(ddrtg_pkg::OP_READ, 1'b0, 2'h0, 1'b0), DA, t2);
    check("txsrd", t2 - t0 >= ddrtg_pkg::XSRD_CYC, 1'b1);
    wait_rd(DA);
    t0 = nref;
    repeat (1200) @(negedge clock);
    check("refresh", nref - t0 >= 2, 1'b1);
    complete_run();
  end
endmodule : test_ddrtg_host
bind ddrtg_host ddrtg_chk i_ddrtg_chk (.clock(clock), .rstn(rstn), .pins(pins),
  .dq_oe_n(dq_oe_n), .dqs_oe_n(dqs_oe_n), .dqs_out(dqs_out));

// ==== verilog/ddrtg_host.sv ====
`timescale 1ns/1ns
module ddrtg_host #(
  parameter int T_RAS_MAX_NS = ddrtg_pkg::T_RAS_MAX_NS,
  parameter int T_REFC_NS = ddrtg_pkg::T_REFC_NS,
  parameter int BL = ddrtg_pkg::BURST_LEN,
  parameter int NB = ddrtg_pkg::NUM_BANKS,
  parameter int LANES = ddrtg_pkg::NUM_LANES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Request side
  input wire ddrtg_pkg::ddrtg_req_t req,
  input wire logic req_valid,
  output logic req_done,
  input wire logic [8*LANES*BL-1:0] wr_data,
  output logic [8*LANES*BL-1:0] rd_data,
  output logic rd_valid,
  output logic in_sref,
  // Memory command pins
  output ddrtg_pkg::ddrtg_pins_t pins,
  // Memory data pins
  output logic [8*LANES-1:0] dq_out,
  output logic [LANES-1:0] dq_oe_n,
  input wire logic [8*LANES-1:0] dq_in,
  output logic [LANES-1:0] dqs_out,
  output logic [LANES-1:0] dqs_oe_n,
  input wire logic [LANES-1:0] dqs_in
);

  localparam int TW = ddrtg_pkg::TMR_W;
  localparam int BW = $clog2(NB);
  localparam int DW = 8 * LANES;
  localparam int RASX_CYC = ddrtg_pkg::cyc_max(T_RAS_MAX_NS) - ddrtg_pkg::URG_MARGIN_CYC;
  localparam int REFC_CYC = ddrtg_pkg::cyc_max(T_REFC_NS);
  localparam int WPH_LEN = BL + 2;
  localparam int PW = $clog2(WPH_LEN + 1);
  localparam int CW = $clog2(BL + 1);

  ddrtg_pkg::ddrtg_pins_t pins_reg;
  ddrtg_pkg::ddrtg_pins_t pins_next;
  ddrtg_pkg::ddrtg_kind_t kind;
  ddrtg_pkg::ddrtg_kind_t req_kind;
  logic [NB-1:0] open_reg;
  logic [NB-1:0] open_next;
  logic [NB-1:0] rcd_done;
  logic [NB-1:0] ras_done;
  logic [NB-1:0] rasx_done;
  logic [NB-1:0] rp_done;
  logic [NB-1:0] act_load;
  logic [NB-1:0] rp_load;
  logic [TW-1:0] rp_val;
  logic [ddrtg_pkg::G_NUM-1:0] g_load;
  logic [ddrtg_pkg::G_NUM-1:0] g_done;
  logic [TW-1:0] g_val [ddrtg_pkg::G_NUM];
  logic [BW-1:0] rb;
  logic pend;
  logic req_ok;
  logic take;
  logic any_open;
  logic close_ok;
  logic ref_ok;
  logic ref_want;
  logic ref_urgent;
  logic done_reg;
  logic done_next;
  logic sref_reg;
  logic sref_next;
  logic [PW-1:0] wph_reg;
  logic [PW-1:0] wph_next;
  logic [8*LANES*BL-1:0] wr_buf_reg;
  logic [8*LANES*BL-1:0] wr_buf_next;
  logic [DW-1:0] dq_reg;
  logic [DW-1:0] dq_next;
  logic [LANES-1:0] dq_oe_n_reg;
  logic [LANES-1:0] dq_oe_n_next;
  logic [LANES-1:0] dqs_reg;
  logic [LANES-1:0] dqs_next;
  logic [LANES-1:0] dqs_oe_n_reg;
  logic [LANES-1:0] dqs_oe_n_next;
  logic rd_pend_reg;
  logic rd_pend_next;
  logic rd_fin;
  logic [LANES-1:0] lane_full;
  logic [8*LANES*BL-1:0] rd_asm;
  logic [8*LANES*BL-1:0] rd_data_reg;
  logic rd_valid_reg;

  // Global spacing timers, one per constraint.
  always_comb begin
    g_val[ddrtg_pkg::G_RRD] = TW'(ddrtg_pkg::RRD_CYC);
    g_val[ddrtg_pkg::G_RFC] = TW'(ddrtg_pkg::RFC_CYC);
    g_val[ddrtg_pkg::G_WTR] = TW'(1 + BL + ddrtg_pkg::WTR_CYC);
    g_val[ddrtg_pkg::G_WR] = TW'(1 + BL + ddrtg_pkg::WR_CYC);
    g_val[ddrtg_pkg::G_MRD] = TW'(ddrtg_pkg::MRD_CYC);
    g_val[ddrtg_pkg::G_XSNR] = TW'(ddrtg_pkg::XSNR_CYC);
    g_val[ddrtg_pkg::G_XSRD] = TW'(ddrtg_pkg::XSRD_CYC);
    g_val[ddrtg_pkg::G_DBUS] = TW'(WPH_LEN);
    g_val[ddrtg_pkg::G_RTW] = TW'(ddrtg_pkg::CAS_LAT + WPH_LEN);
  end

  for (genvar g = 0; g < ddrtg_pkg::G_NUM; g++) begin : g_glob
    ddrtg_timer #(.W(TW)) u_tmr (
      .clock(clock),
      .rstn(rstn),
      .load(g_load[g]),
      .value(g_val[g]),
      .done(g_done[g])
    );
  end

  // Per-bank timers: activate to access, open time limits, precharge recovery.
  for (genvar b = 0; b < NB; b++) begin : g_bank
    ddrtg_timer #(.W(TW)) u_rcd (
      .clock(clock), .rstn(rstn), .load(act_load[b]),
      .value(TW'(ddrtg_pkg::RCD_CYC)), .done(rcd_done[b])
    );
    ddrtg_timer #(.W(TW)) u_ras (
      .clock(clock), .rstn(rstn), .load(act_load[b]),
      .value(TW'(ddrtg_pkg::RAS_MIN_CYC)), .done(ras_done[b])
    );
    ddrtg_timer #(.W(TW)) u_rasx (
      .clock(clock), .rstn(rstn), .load(act_load[b]),
      .value(TW'(RASX_CYC)), .done(rasx_done[b])
    );
    ddrtg_timer #(.W(TW)) u_rp (
      .clock(clock), .rstn(rstn), .load(rp_load[b]),
      .value(rp_val), .done(rp_done[b])
    );
  end

  ddrtg_refresh #(
    .REFI_CYC(ddrtg_pkg::REFI_CYC),
    .REFC_CYC(REFC_CYC),
    .POST_MAX(ddrtg_pkg::POST_MAX),
    .MARGIN(ddrtg_pkg::URG_MARGIN_CYC)
  ) u_refresh (
    .clock(clock),
    .rstn(rstn),
    .hold(sref_reg),
    .issued(kind == ddrtg_pkg::K_REF),
    .want(ref_want),
    .urgent(ref_urgent)
  );

  // Legality of the pending request.
  always_comb begin
    rb = {req.rank, req.ba};
    any_open = |open_reg;
    req_ok = 1'b0;
    req_kind = ddrtg_pkg::K_NONE;
    case (req.op)
      ddrtg_pkg::OP_ACT: begin
        req_kind = ddrtg_pkg::K_ACT;
        req_ok = !open_reg[rb] && rp_done[rb] && g_done[ddrtg_pkg::G_RRD]
          && g_done[ddrtg_pkg::G_RFC] && g_done[ddrtg_pkg::G_XSNR];
      end
      ddrtg_pkg::OP_READ: begin
        req_kind = ddrtg_pkg::K_RD;
        req_ok = open_reg[rb] && rcd_done[rb] && g_done[ddrtg_pkg::G_WTR]
          && g_done[ddrtg_pkg::G_XSRD] && g_done[ddrtg_pkg::G_DBUS]
          && (!req.ap || ras_done[rb]);
      end
      ddrtg_pkg::OP_WRITE: begin
        req_kind = ddrtg_pkg::K_WR;
        req_ok = open_reg[rb] && rcd_done[rb] && g_done[ddrtg_pkg::G_XSNR]
          && g_done[ddrtg_pkg::G_DBUS] && g_done[ddrtg_pkg::G_RTW]
          && (!req.ap || ras_done[rb]);
      end
      ddrtg_pkg::OP_PRE: begin
        req_kind = ddrtg_pkg::K_PRE;
        req_ok = (!open_reg[rb] || ras_done[rb]) && g_done[ddrtg_pkg::G_WR]
          && g_done[ddrtg_pkg::G_XSNR];
      end
      ddrtg_pkg::OP_MRS: begin
        req_kind = ddrtg_pkg::K_MRS;
        req_ok = !any_open && (&rp_done) && g_done[ddrtg_pkg::G_MRD]
          && g_done[ddrtg_pkg::G_RFC] && g_done[ddrtg_pkg::G_XSNR];
      end
      ddrtg_pkg::OP_SREF_IN: begin
        req_kind = ddrtg_pkg::K_SRE;
        req_ok = !any_open && (&rp_done) && g_done[ddrtg_pkg::G_RFC]
          && g_done[ddrtg_pkg::G_XSNR];
      end
      ddrtg_pkg::OP_SREF_OUT: begin
        req_ok = 1'b1;
      end
      default: begin
        req_ok = 1'b0;
      end
    endcase
  end

  // Command choice: forced closes and refresh beat the user, who beats lazy refresh.
  always_comb begin
    pend = req_valid && !done_reg;
    close_ok = (&(~open_reg | ras_done)) && g_done[ddrtg_pkg::G_WR];
    ref_ok = !any_open && (&rp_done) && g_done[ddrtg_pkg::G_RFC] && g_done[ddrtg_pkg::G_XSNR];
    kind = ddrtg_pkg::K_NONE;
    take = 1'b0;
    if (sref_reg) begin
      if (pend && req.op == ddrtg_pkg::OP_SREF_OUT) begin
        kind = ddrtg_pkg::K_SRX;
        take = 1'b1;
      end
    end else if (((|(open_reg & rasx_done)) || ref_urgent) && any_open) begin
      if (close_ok && g_done[ddrtg_pkg::G_XSNR]) begin
        kind = ddrtg_pkg::K_PREALL;
      end
    end else if (ref_urgent) begin
      if (ref_ok) begin
        kind = ddrtg_pkg::K_REF;
      end
    end else if (pend && req_ok) begin
      kind = req_kind;
      take = 1'b1;
    end else if (ref_want && ref_ok && !pend) begin
      kind = ddrtg_pkg::K_REF;
    end
  end

  // Command pins and bank state.
  always_comb begin
    pins_next = pins_reg;
    pins_next.cs_n = 2'h3;
    {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = ddrtg_pkg::CMD_NOP;
    open_next = open_reg;
    act_load = '0;
    rp_load = '0;
    rp_val = TW'(ddrtg_pkg::RP_CYC);
    g_load = '0;
    sref_next = sref_reg;
    done_next = take;
    case (kind)
      ddrtg_pkg::K_ACT: begin
        pins_next.cs_n[req.rank] = 1'b0;
        {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = ddrtg_pkg::CMD_ACT;
        pins_next.ba = req.ba;
        pins_next.addr = req.addr;
        open_next[rb] = 1'b1;
        act_load[rb] = 1'b1;
        g_load[ddrtg_pkg::G_RRD] = 1'b1;
      end
      ddrtg_pkg::K_RD, ddrtg_pkg::K_WR: begin
        pins_next.cs_n[req.rank] = 1'b0;
        {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} =
          (kind == ddrtg_pkg::K_RD) ? ddrtg_pkg::CMD_READ : ddrtg_pkg::CMD_WRITE;
        pins_next.ba = req.ba;
        pins_next.addr = req.addr;
        pins_next.addr[ddrtg_pkg::AP_BIT] = req.ap;
        g_load[ddrtg_pkg::G_DBUS] = 1'b1;
        if (kind == ddrtg_pkg::K_RD) begin
          g_load[ddrtg_pkg::G_RTW] = 1'b1;
          rp_val = TW'(BL + ddrtg_pkg::RP_CYC);
        end else begin
          g_load[ddrtg_pkg::G_WTR] = 1'b1;
          g_load[ddrtg_pkg::G_WR] = 1'b1;
          rp_val = TW'(1 + BL + ddrtg_pkg::WR_CYC + ddrtg_pkg::RP_CYC);
        end
        if (req.ap) begin
          open_next[rb] = 1'b0;
          rp_load[rb] = 1'b1;
        end
      end
      ddrtg_pkg::K_PRE: begin
        pins_next.cs_n[req.rank] = 1'b0;
        {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = ddrtg_pkg::CMD_PRE;
        pins_next.ba = req.ba;
        pins_next.addr[ddrtg_pkg::AP_BIT] = 1'b0;
        open_next[rb] = 1'b0;
        rp_load[rb] = 1'b1;
      end
      ddrtg_pkg::K_PREALL: begin
        pins_next.cs_n = 2'h0;
        {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = ddrtg_pkg::CMD_PRE;
        pins_next.addr[ddrtg_pkg::AP_BIT] = 1'b1;
        open_next = '0;
        rp_load = open_reg;
      end
      ddrtg_pkg::K_REF: begin
        pins_next.cs_n = 2'h0;
        pins_next.cke = 1'b1;
        {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = ddrtg_pkg::CMD_REF;
        g_load[ddrtg_pkg::G_RFC] = 1'b1;
      end
      ddrtg_pkg::K_MRS: begin
        pins_next.cs_n = 2'h0;
        {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = ddrtg_pkg::CMD_MRS;
        pins_next.ba = req.ba;
        pins_next.addr = req.addr;
        g_load[ddrtg_pkg::G_MRD] = 1'b1;
      end
      ddrtg_pkg::K_SRE: begin
        pins_next.cs_n = 2'h0;
        pins_next.cke = 1'b0;
        {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = ddrtg_pkg::CMD_REF;
        sref_next = 1'b1;
      end
      ddrtg_pkg::K_SRX: begin
        pins_next.cke = 1'b1;
        sref_next = 1'b0;
        g_load[ddrtg_pkg::G_XSNR] = 1'b1;
        g_load[ddrtg_pkg::G_XSRD] = 1'b1;
      end
      default: begin
        pins_next.cs_n = 2'h3;
      end
    endcase
  end

  // Write launch: strobe goes low with the WRITE command, toggles once per beat.
  always_comb begin
    wph_next = '0;
    if (kind == ddrtg_pkg::K_WR) begin
      wph_next = PW'(WPH_LEN);
    end else if (wph_reg != '0) begin
      wph_next = wph_reg - 1'b1;
    end
    wr_buf_next = (kind == ddrtg_pkg::K_WR) ? wr_data : wr_buf_reg;
    dq_next = dq_reg;
    dq_oe_n_next = '1;
    dqs_next = '0;
    dqs_oe_n_next = (wph_next == '0) ? '1 : '0;
    if (wph_next >= PW'(2) && wph_next <= PW'(BL + 1)) begin
      dqs_next = ~dqs_reg;
      dq_oe_n_next = '0;
      dq_next = wr_buf_reg[(WPH_LEN - 1 - int'(wph_next)) * DW +: DW];
    end
  end

  // Read capture: each lane shifts its own byte on its own strobe edges.
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [8*BL-1:0] sh_reg;
    logic [8*BL-1:0] sh_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic prev_reg;

    always_comb begin
      sh_next = sh_reg;
      cnt_next = cnt_reg;
      if (rd_fin) begin
        cnt_next = '0;
      end else if (rd_pend_reg && (dqs_in[l] ^ prev_reg) && cnt_reg != CW'(BL)) begin
        sh_next = {dq_in[8*l +: 8], sh_reg[8*BL-1:8]};
        cnt_next = cnt_reg + 1'b1;
      end
    end

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        sh_reg <= '0;
        cnt_reg <= '0;
        prev_reg <= 1'b0;
      end else begin
        sh_reg <= sh_next;
        cnt_reg <= cnt_next;
        prev_reg <= dqs_in[l];
      end
    end

    assign lane_full[l] = (cnt_reg == CW'(BL));
    for (genvar k = 0; k < BL; k++) begin : g_beat
      assign rd_asm[(k*LANES + l)*8 +: 8] = sh_reg[8*k +: 8];
    end
  end

  // Lanes finish independently; the word is handed over once all are full.
  assign rd_fin = rd_pend_reg && (&lane_full);
  assign rd_pend_next = (rd_pend_reg && !rd_fin) || (kind == ddrtg_pkg::K_RD);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pins_reg <= ddrtg_pkg::PINS_IDLE;
      open_reg <= '0;
      sref_reg <= 1'b0;
      done_reg <= 1'b0;
      wph_reg <= '0;
      wr_buf_reg <= '0;
      dq_reg <= '0;
      dq_oe_n_reg <= '1;
      dqs_reg <= '0;
      dqs_oe_n_reg <= '1;
      rd_pend_reg <= 1'b0;
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      pins_reg <= pins_next;
      open_reg <= open_next;
      sref_reg <= sref_next;
      done_reg <= done_next;
      wph_reg <= wph_next;
      wr_buf_reg <= wr_buf_next;
      dq_reg <= dq_next;
      dq_oe_n_reg <= dq_oe_n_next;
      dqs_reg <= dqs_next;
      dqs_oe_n_reg <= dqs_oe_n_next;
      rd_pend_reg <= rd_pend_next;
      rd_data_reg <= rd_fin ? rd_asm : rd_data_reg;
      rd_valid_reg <= rd_fin;
    end
  end

  assign pins = pins_reg;
  assign req_done = done_reg;
  assign in_sref = sref_reg;
  assign dq_out = dq_reg;
  assign dq_oe_n = dq_oe_n_reg;
  assign dqs_out = dqs_reg;
  assign dqs_oe_n = dqs_oe_n_reg;
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;

endmodule : ddrtg_host

// ==== verilog/ddrtg_pkg.sv ====
package ddrtg_pkg;

  // Controller clock period.
  localparam int CLK_NS = 4;

  // Least times round up, longest times round down, never below one cycle.
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_max

  // Memory timing in its own units.
  localparam int T_RFC_NS = 70;
  localparam int T_RCD_NS = 15;
  localparam int T_RP_NS = 15;
  localparam int T_RRD_NS = 10;
  localparam int T_WTR_CK = 2;
  localparam int T_REFI_NS = 7800;
  localparam int T_REFC_NS = 70300;
  localparam int T_XSNR_NS = 70;
  localparam int T_XSRD_CK = 200;
  localparam int T_RAS_MIN_NS = 40;
  localparam int T_RAS_MAX_NS = 70000;
  localparam int T_MRD_NS = 10;
  localparam int T_WR_NS = 15;
  localparam int T_REFW_MS = 64;
  localparam int REF_ROWS = 8192;
  localparam int REFW_AVG_NS = T_REFW_MS * 1000000 / REF_ROWS;
  localparam int REFI_USE_NS = (T_REFI_NS < REFW_AVG_NS) ? T_REFI_NS : REFW_AVG_NS;

  // Derived cycle counts.
  localparam int RFC_CYC = cyc_min(T_RFC_NS);
  localparam int RCD_CYC = cyc_min(T_RCD_NS);
  localparam int RP_CYC = cyc_min(T_RP_NS);
  localparam int RRD_CYC = cyc_min(T_RRD_NS);
  localparam int WTR_CYC = T_WTR_CK;
  localparam int REFI_CYC = cyc_max(REFI_USE_NS);
  localparam int XSNR_CYC = cyc_min(T_XSNR_NS);
  localparam int XSRD_CYC = T_XSRD_CK;
  localparam int RAS_MIN_CYC = cyc_min(T_RAS_MIN_NS);
  localparam int MRD_CYC = cyc_min(T_MRD_NS);
  localparam int WR_CYC = cyc_min(T_WR_NS);

  // Structure.
  localparam int BURST_LEN = 4;
  localparam int CAS_LAT = 3;
  localparam int NUM_BANKS = 8;
  localparam int NUM_LANES = 8;
  localparam int POST_MAX = 8;
  localparam int URG_MARGIN_CYC = 64;
  localparam int TMR_W = 16;
  localparam int AP_BIT = 10;

  // Global timer slots.
  localparam int G_RRD = 0;
  localparam int G_RFC = 1;
  localparam int G_WTR = 2;
  localparam int G_WR = 3;
  localparam int G_MRD = 4;
  localparam int G_XSNR = 5;
  localparam int G_XSRD = 6;
  localparam int G_DBUS = 7;
  localparam int G_RTW = 8;
  localparam int G_NUM = 9;

  // Command codes as {ras_n, cas_n, we_n}.
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;

  typedef enum logic [2:0] {
    OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_MRS, OP_SREF_IN, OP_SREF_OUT
  } ddrtg_op_t;

  typedef enum logic [3:0] {
    K_NONE, K_ACT, K_RD, K_WR, K_PRE, K_PREALL, K_REF, K_MRS, K_SRE, K_SRX
  } ddrtg_kind_t;

  typedef struct packed {
    ddrtg_op_t op;
    logic rank;
    logic [1:0] ba;
    logic [12:0] addr;
    logic ap;
  } ddrtg_req_t;

  typedef struct packed {
    logic cke;
    logic [1:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] addr;
  } ddrtg_pins_t;

  localparam ddrtg_pins_t PINS_IDLE = '{cke: 1'b1, cs_n: 2'h3, ras_n: 1'b1, cas_n: 1'b1,
                                       we_n: 1'b1, ba: 2'h0, addr: 13'h0000};

endpackage : ddrtg_pkg

// ==== verilog/ddrtg_refresh.sv ====
`timescale 1ns/1ns
module ddrtg_refresh #(
  parameter int REFI_CYC = ddrtg_pkg::REFI_CYC,
  parameter int REFC_CYC = ddrtg_pkg::cyc_max(ddrtg_pkg::T_REFC_NS),
  parameter int POST_MAX = ddrtg_pkg::POST_MAX,
  parameter int MARGIN = ddrtg_pkg::URG_MARGIN_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Scheduling
  input wire logic hold,
  input wire logic issued,
  output logic want,
  output logic urgent
);

  localparam int TW = $clog2(REFI_CYC + 1);
  localparam int GW = $clog2(REFC_CYC + 1);
  localparam int OW = $clog2(POST_MAX + 2);

  logic [TW-1:0] tick_reg;
  logic [TW-1:0] tick_next;
  logic [GW-1:0] gap_reg;
  logic [GW-1:0] gap_next;
  logic [OW-1:0] owed_reg;
  logic [OW-1:0] owed_next;
  logic tick;

  always_comb begin
    tick = (tick_reg == TW'(REFI_CYC - 1));
    tick_next = (hold || tick) ? '0 : tick_reg + 1'b1;
    gap_next = gap_reg;
    if (hold || issued) begin
      gap_next = '0;
    end else if (gap_reg != GW'(REFC_CYC)) begin
      gap_next = gap_reg + 1'b1;
    end
    owed_next = owed_reg;
    if (hold) begin
      owed_next = '0;
    end else if (tick && !issued && owed_reg != OW'(POST_MAX + 1)) begin
      owed_next = owed_reg + 1'b1;
    end else if (!tick && issued && owed_reg != '0) begin
      owed_next = owed_reg - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_reg <= '0;
      gap_reg <= '0;
      owed_reg <= '0;
    end else begin
      tick_reg <= tick_next;
      gap_reg <= gap_next;
      owed_reg <= owed_next;
    end
  end

  // Refresh is wanted only while owed, but the gap limit can force one early; early ones earn no credit, so the schedule cannot run ahead.
  assign want = (owed_reg != '0);
  assign urgent = (owed_reg >= OW'(POST_MAX - 1)) || (gap_reg >= GW'(REFC_CYC - MARGIN));

endmodule : ddrtg_refresh

// ==== verilog/ddrtg_timer.sv ====
`timescale 1ns/1ns
module ddrtg_timer #(
  parameter int W = ddrtg_pkg::TMR_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Load and status
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = value;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0);

endmodule : ddrtg_timer
